// [inc/epi_pkg.sv]
/*
  Package for the external pin interrupt unit: sense codes, vector addresses,
  reset values and the structs that carry request flags and per-source enables.
  Assumes a single 50 MHz clock domain and no register bus.
*/
package epi_pkg;

  localparam int EPI_CLK_MHZ = 50;
  localparam int EPI_CLK_PERIOD_NS = 20;

  // Sense-control codes per dedicated pin
  typedef enum logic [1:0] {
    EPI_SENSE_LOW = 2'h0,
    EPI_SENSE_ANY = 2'h1,
    EPI_SENSE_FALL = 2'h2,
    EPI_SENSE_RISE = 2'h3
  } epi_sense_e;

  // Vector word addresses on the larger memory variant
  localparam logic [15:0] EPI_VEC_NONE = 16'h0000;
  localparam logic [15:0] EPI_VEC_PIN_ZERO = 16'h0002;
  localparam logic [15:0] EPI_VEC_PIN_ONE = 16'h0004;
  localparam logic [15:0] EPI_VEC_LOWER_GRP = 16'h0006;
  localparam logic [15:0] EPI_VEC_UPPER_GRP = 16'h0008;

  // Field positions inside the sense-control register
  localparam int EPI_SENSE_ZERO_LSB = 0;
  localparam int EPI_SENSE_ONE_LSB = 2;

  localparam logic [3:0] EPI_SENSE_RST = 4'h0;
  localparam logic [7:0] EPI_MASK_RST = 8'h00;
  localparam logic [1:0] EPI_FLAG_RST = 2'h0;
  localparam logic [15:0] EPI_PINS_RST = 16'h0000;
  localparam logic [1:0] EPI_DED_RST = 2'h3;
  // Start-up period length from fuses, counted in clock cycles
  localparam logic [15:0] EPI_STARTUP_RST = 16'h0000;

  // Request flags: bit 0 for pin zero / lower group, bit 1 for pin one / upper group
  typedef struct packed {
    logic [1:0] dedicated;
    logic [1:0] change;
  } epi_flags_s;

  // Per-source enables
  typedef struct packed {
    logic [1:0] dedicated;
    logic [1:0] change;
  } epi_enables_s;

endpackage : epi_pkg

// [rtl/epi_unit.sv]
/*
  External pin interrupt unit: two dedicated interrupt pins with selectable
  sense and two masked groups of eight pin-change inputs, with request flags,
  vector selection and a wake signal.
  Assumes pins arrive asynchronously, the CPU acknowledges a taken vector
  with a one-cycle pulse, and a clock-control block supplies io_clk_en and
  the start-up timing from the fuses.
*/
`timescale 1ns/100ps
module epi_unit
  import epi_pkg::*;
(
  input wire logic clk, // System clock, 50 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic io_clk_en, // High while the I/O clock runs
  input wire logic in_deep_sleep, // High in a sleep mode other than idle
  input wire logic [15:0] startup_cycles, // Start-up period from the fuses
  input wire logic [1:0] dedicated_irq_pins, // Dedicated pin levels, async
  input wire logic [15:0] pin_change_inputs, // Pin-change levels, async
  input wire logic [3:0] sense_control_reg, // Two sense fields, pin one high
  input wire logic [7:0] upper_change_mask, // Mask for inputs 15..8
  input wire logic [7:0] lower_change_mask, // Mask for inputs 7..0
  input wire epi_enables_s enables, // Per-source enables
  input wire logic global_irq_en, // CPU global interrupt enable
  input wire epi_flags_s flag_clear, // Firmware write-one-to-clear
  input wire logic vector_taken, // CPU took the presented vector
  output epi_flags_s flags, // Visible flag bits
  output logic [1:0] level_request, // Level-mode requests on dedicated pins
  output logic irq_pending, // An enabled request waits
  output logic [15:0] irq_vector, // Vector of highest priority request
  output logic wake // Wake request to the sleep controller
);

  logic [1:0] ded_meta_r, ded_meta_nxt;
  logic [1:0] ded_sync_r, ded_sync_nxt;
  logic [1:0] ded_prev_r, ded_prev_nxt;
  logic [15:0] pc_meta_r, pc_meta_nxt;
  logic [15:0] pc_sync_r, pc_sync_nxt;
  logic [15:0] pc_prev_r, pc_prev_nxt;
  epi_flags_s flag_r, flag_nxt;
  logic [1:0] lvl_r, lvl_nxt;
  logic pend_r, pend_nxt;
  logic [15:0] vec_r, vec_nxt;
  logic wake_r, wake_nxt;
  logic [15:0] su_cnt_r, su_cnt_nxt;
  logic [1:0] su_hold_r, su_hold_nxt;
  logic su_run_r, su_run_nxt;

  // True when the sense code asks for level detection
  function automatic logic is_level(input logic [1:0] code);
    is_level = (epi_sense_e'(code) == EPI_SENSE_LOW);
  endfunction : is_level

  // Edge event for one dedicated pin according to its sense code
  function automatic logic edge_hit(input logic [1:0] code, input logic cur,
                                    input logic prev);
    unique case (epi_sense_e'(code))
      EPI_SENSE_LOW: edge_hit = 1'b0;
      EPI_SENSE_ANY: edge_hit = cur ^ prev;
      EPI_SENSE_FALL: edge_hit = prev & ~cur;
      EPI_SENSE_RISE: edge_hit = ~prev & cur;
    endcase
  endfunction : edge_hit

  logic [1:0] sense [2];
  logic [1:0] edge_ev;
  logic [1:0] low_now;
  logic [1:0] pc_grp_ev;
  logic [15:0] pc_diff;
  logic [1:0] any_flag;

  always_comb begin
    sense[0] = sense_control_reg[EPI_SENSE_ZERO_LSB +: 2];
    sense[1] = sense_control_reg[EPI_SENSE_ONE_LSB +: 2];
    // Pins are read as levels regardless of direction, so driving them raises requests
    pc_diff = pc_sync_r ^ pc_prev_r;
    pc_grp_ev[1] = |(pc_diff[15:8] & upper_change_mask);
    pc_grp_ev[0] = |(pc_diff[7:0] & lower_change_mask);
    for (int i = 0; i < 2; i++) begin
      // Edges only recognised while the I/O clock runs
      edge_ev[i] = io_clk_en & ~in_deep_sleep &
                   edge_hit(sense[i], ded_sync_r[i], ded_prev_r[i]);
      low_now[i] = ~ded_sync_r[i];
    end
  end

  always_comb begin
    ded_meta_nxt = dedicated_irq_pins;
    ded_sync_nxt = ded_meta_r;
    // Always tracks, so an edge that falls while the I/O clock is off is lost
    ded_prev_nxt = ded_sync_r;
    pc_meta_nxt = pin_change_inputs;
    pc_sync_nxt = pc_meta_r;
    pc_prev_nxt = pc_sync_r;
    su_cnt_nxt = su_cnt_r;
    su_run_nxt = su_run_r;
    su_hold_nxt = su_hold_r;
    flag_nxt = flag_r;
    lvl_nxt = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (is_level(sense[i])) begin
        flag_nxt.dedicated[i] = 1'b0;
      end else begin
        if (flag_clear.dedicated[i]) begin
          flag_nxt.dedicated[i] = 1'b0;
        end
        if (edge_ev[i]) begin
          flag_nxt.dedicated[i] = 1'b1;
        end
      end
      if (flag_clear.change[i]) begin
        flag_nxt.change[i] = 1'b0;
      end
      if (pc_grp_ev[i]) begin
        flag_nxt.change[i] = 1'b1;
      end
    end
    // Start-up window after a deep-sleep wake: a low level must last through it
    if (wake_r && !su_run_r) begin
      su_run_nxt = 1'b1;
      su_cnt_nxt = startup_cycles;
      su_hold_nxt = 2'h3;
    end else if (su_run_r) begin
      su_hold_nxt = su_hold_r & low_now;
      if (su_cnt_r == 16'h0000) begin
        su_run_nxt = 1'b0;
      end else begin
        su_cnt_nxt = su_cnt_r - 16'h0001;
      end
    end
    for (int i = 0; i < 2; i++) begin
      // Level request held while low; none while asleep or during start-up
      lvl_nxt[i] = enables.dedicated[i] & is_level(sense[i]) & low_now[i] &
                   ~in_deep_sleep & ~su_run_r & su_hold_r[i];
    end
    if (!su_run_r && !wake_r) begin
      su_hold_nxt = 2'h3;
    end
    // Taken vector clears its source flag; a fresh event in that cycle still wins
    if (vector_taken) begin
      unique case (vec_r)
        EPI_VEC_PIN_ZERO: flag_nxt.dedicated[0] = edge_ev[0];
        EPI_VEC_PIN_ONE: flag_nxt.dedicated[1] = edge_ev[1];
        EPI_VEC_LOWER_GRP: flag_nxt.change[0] = pc_grp_ev[0];
        EPI_VEC_UPPER_GRP: flag_nxt.change[1] = pc_grp_ev[1];
        default: flag_nxt = flag_nxt;
      endcase
    end
  end

  always_comb begin
    any_flag[0] = (flag_r.dedicated[0] & enables.dedicated[0]) | lvl_r[0];
    any_flag[1] = (flag_r.dedicated[1] & enables.dedicated[1]) | lvl_r[1];
    pend_nxt = 1'b0;
    vec_nxt = EPI_VEC_NONE;
    if (global_irq_en && !vector_taken) begin
      // Fixed priority, lowest vector first
      if (any_flag[0]) begin
        pend_nxt = 1'b1;
        vec_nxt = EPI_VEC_PIN_ZERO;
      end else if (any_flag[1]) begin
        pend_nxt = 1'b1;
        vec_nxt = EPI_VEC_PIN_ONE;
      end else if (flag_r.change[0] && enables.change[0]) begin
        pend_nxt = 1'b1;
        vec_nxt = EPI_VEC_LOWER_GRP;
      end else if (flag_r.change[1] && enables.change[1]) begin
        pend_nxt = 1'b1;
        vec_nxt = EPI_VEC_UPPER_GRP;
      end
    end
    // Wake from synchronised pins: only the I/O clock stops, the core clock keeps running
    wake_nxt = in_deep_sleep &
               ((|(pc_grp_ev & enables.change)) |
                (|(flag_r.change & enables.change)) |
                (enables.dedicated[0] & is_level(sense[0]) & low_now[0]) |
                (enables.dedicated[1] & is_level(sense[1]) & low_now[1]));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ded_meta_r <= EPI_DED_RST;
      ded_sync_r <= EPI_DED_RST;
      ded_prev_r <= EPI_DED_RST;
      pc_meta_r <= EPI_PINS_RST;
      pc_sync_r <= EPI_PINS_RST;
      pc_prev_r <= EPI_PINS_RST;
      flag_r <= '0;
      lvl_r <= EPI_FLAG_RST;
      pend_r <= 1'b0;
      vec_r <= EPI_VEC_NONE;
      wake_r <= 1'b0;
      su_cnt_r <= EPI_STARTUP_RST;
      su_hold_r <= EPI_DED_RST;
      su_run_r <= 1'b0;
    end else begin
      ded_meta_r <= ded_meta_nxt;
      ded_sync_r <= ded_sync_nxt;
      ded_prev_r <= ded_prev_nxt;
      pc_meta_r <= pc_meta_nxt;
      pc_sync_r <= pc_sync_nxt;
      pc_prev_r <= pc_prev_nxt;
      flag_r <= flag_nxt;
      lvl_r <= lvl_nxt;
      pend_r <= pend_nxt;
      vec_r <= vec_nxt;
      wake_r <= wake_nxt;
      su_cnt_r <= su_cnt_nxt;
      su_hold_r <= su_hold_nxt;
      su_run_r <= su_run_nxt;
    end
  end

  assign flags = flag_r;
  assign level_request = lvl_r;
  assign irq_pending = pend_r;
  assign irq_vector = vec_r;
  assign wake = wake_r;

endmodule : epi_unit

// [testbench/epi_unit_chk.sv]
/* Port checker for epi_unit.
   Bound to the unit from the bench top; sees its ports only. */
`timescale 1ns/100ps
module epi_unit_chk
  import epi_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic io_clk_en, // I/O clock on
  input wire logic in_deep_sleep, // Deep sleep
  input wire logic [3:0] sense_control_reg, // Sense fields
  input wire logic [7:0] upper_change_mask, // Upper mask
  input wire epi_enables_s enables, // Enables
  input wire logic global_irq_en, // Global enable
  input wire epi_flags_s flag_clear, // Clears
  input wire logic vector_taken, // Taken
  input wire epi_flags_s flags, // Flags
  input wire logic [1:0] level_request, // Level requests
  input wire logic irq_pending, // Pending
  input wire logic [15:0] irq_vector, // Vector
  input wire logic wake // Wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_lvl_flag_zero: assert property (
    (sense_control_reg[3:2] == 2'h0) [*2] |-> !flags.dedicated[1])
    else $error("dedicated flag set in level mode");
  a_edge_needs_clk: assert property (
    (!io_clk_en) [*2] |=> !$rose(flags.dedicated[0]))
    else $error("edge flag set without io clock");
  a_sleep_no_edge: assert property (
    in_deep_sleep [*2] |=> !$rose(flags.dedicated[1]))
    else $error("edge flag set in deep sleep");
  a_vec_pin_zero: assert property (
    flags.dedicated[0] && enables.dedicated[0] && global_irq_en && !vector_taken
    && !flag_clear.dedicated[0] |=> irq_vector == EPI_VEC_PIN_ZERO)
    else $error("pin zero vector wrong");
  a_vec_upper_grp: assert property (
    flags == 4'h2 && level_request == 2'h0 && enables.change[1] && global_irq_en && !vector_taken
    && !flag_clear.change[1] |=> irq_vector == EPI_VEC_UPPER_GRP)
    else $error("upper group vector wrong");
  a_taken_drops: assert property (
    vector_taken |=> !irq_pending)
    else $error("pending after vector taken");
  a_mask_blocks: assert property (
    (upper_change_mask == 8'h00) [*4] |=> !$rose(flags.change[1]))
    else $error("masked upper group raised");
  a_level_cause: assert property (
    level_request[1] |-> $past(sense_control_reg[3:2]) == 2'h0)
    else $error("level request outside level mode");
  a_wake_sleep: assert property (
    $rose(wake) |-> $past(in_deep_sleep))
    else $error("wake outside deep sleep");
endmodule : epi_unit_chk

// [testbench/epi_pins.sv]
/* Off-chip pin drivers, or firmware driving the pins as outputs.
   Changes land just after a rising clock edge. */
`timescale 1ns/100ps
module epi_pins (
  input wire logic clk, // Clock
  output logic [1:0] ded, // Dedicated pins
  output logic [15:0] chg // Pin-change inputs
);
  initial begin
    ded = 2'h3;
    chg = 16'h0000;
  end
  // Levels are held until the next call, so the caller decides whether a waking low outlasts start-up
  task drive(input logic [1:0] d, input logic [15:0] c);
    @(posedge clk);
    ded <= d;
    chg <= c;
  endtask : drive
endmodule : epi_pins

// [testbench/epi_unit_tb_top.sv]
/* Self-checking bench for epi_unit.
   Pins come from epi_pins; all other inputs from here. */
`timescale 1ns/100ps
module epi_unit_tb_top;
  import epi_pkg::*;
  logic clk, rstn, io_clk_en, in_deep_sleep, gie, vtak, pend, wake;
  logic [15:0] startup_cycles, vec, chg;
  logic [1:0] ded, lvl;
  logic [3:0] sense;
  logic [7:0] umask, lmask;
  epi_enables_s en;
  epi_flags_s fclr, flags;
  int n_errors, checks, i;
  epi_pins pins (.clk(clk), .ded(ded), .chg(chg));
  epi_unit DUT (.clk(clk), .rstn(rstn), .io_clk_en(io_clk_en),
    .in_deep_sleep(in_deep_sleep), .startup_cycles(startup_cycles),
    .dedicated_irq_pins(ded), .pin_change_inputs(chg), .sense_control_reg(sense),
    .upper_change_mask(umask), .lower_change_mask(lmask), .enables(en),
    .global_irq_en(gie), .flag_clear(fclr), .vector_taken(vtak), .flags(flags),
    .level_request(lvl), .irq_pending(pend), .irq_vector(vec), .wake(wake));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task clr;
    @(posedge clk) fclr <= 4'hf;
    @(posedge clk) fclr <= 4'h0;
    wt(2);
  endtask : clr
  task wrap_up;
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task t_fall_vec;
    pins.drive(2'h2, 16'h0000);
    wt(4);
    cmp({12'h000, flags}, 16'h0004);
    for (i = 0; i < 8 && pend !== 1'b1; i++) wt(1);
    if (pend !== 1'b1) begin
      n_errors++;
      wrap_up;
    end
    cmp(vec, 16'h0002);
    @(posedge clk) vtak <= 1'b1;
    @(posedge clk) vtak <= 1'b0;
    #1;
    cmp({11'h000, pend, flags}, 16'h0000);
    pins.drive(2'h3, 16'h0000);
    wt(5);
  endtask : t_fall_vec
  task t_codes;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      sense <= {c[1:0], 2'h2};
      pins.drive(2'h1, 16'h0000);
      wt(5);
      cmp({flags.dedicated[1], lvl[1]}, {c == 1 || c == 2, c == 0});
      pins.drive(2'h3, 16'h0000);
      wt(5);
      cmp({flags.dedicated[1], lvl[1]}, {c != 0, 1'b0});
      cmp(vec, (c != 0) ? 16'h0004 : 16'h0000);
      clr;
    end
  endtask : t_codes
  task t_change;
    @(posedge clk);
    lmask <= 8'h08;
    pins.drive(2'h3, 16'h1000);
    wt(5);
    cmp({12'h000, flags}, 16'h0000);
    pins.drive(2'h3, 16'h1008);
    wt(5);
    cmp({12'h000, flags}, 16'h0001);
    clr;
    @(posedge clk);
    umask <= 8'h10;
    pins.drive(2'h3, 16'h0008);
    wt(5);
    cmp({12'h000, flags}, 16'h0002);
    cmp(vec, 16'h0008);
    clr;
  endtask : t_change
  task t_sleep;
    @(posedge clk);
    io_clk_en <= 1'b0;
    in_deep_sleep <= 1'b1;
    pins.drive(2'h2, 16'h0008);
    wt(5);
    cmp({15'h0000, flags.dedicated[0]}, 16'h0000);
    pins.drive(2'h2, 16'h0000);
    wt(3);
    cmp({15'h0000, wake}, 16'h0001);
    cmp({12'h000, flags}, 16'h0001);
    @(posedge clk);
    io_clk_en <= 1'b1;
    in_deep_sleep <= 1'b0;
    pins.drive(2'h3, 16'h0000);
    wt(startup_cycles + 8);
    clr;
  endtask : t_sleep
  // Level wake on pin zero: held through start-up, then dropped inside it
  task t_startup;
    @(posedge clk);
    sense <= 4'hc;
    in_deep_sleep <= 1'b1;
    io_clk_en <= 1'b0;
    pins.drive(2'h2, 16'h0000);
    wt(3);
    cmp({13'h0000, wake, lvl}, 16'h0004);
    @(posedge clk);
    in_deep_sleep <= 1'b0;
    io_clk_en <= 1'b1;
    wt(3);
    cmp({14'h0000, lvl}, 16'h0000);
    wt(4);
    cmp({13'h0000, pend, lvl}, 16'h0005);
    pins.drive(2'h3, 16'h0000);
    wt(4);
    @(posedge clk);
    in_deep_sleep <= 1'b1;
    io_clk_en <= 1'b0;
    pins.drive(2'h2, 16'h0000);
    wt(3);
    @(posedge clk);
    in_deep_sleep <= 1'b0;
    io_clk_en <= 1'b1;
    pins.drive(2'h3, 16'h0000);
    wt(1);
    cmp({13'h0000, pend, lvl}, 16'h0000);
    wt(8);
    cmp({13'h0000, pend, lvl}, 16'h0000);
  endtask : t_startup
  initial begin
    rstn = 1'b0;
    io_clk_en = 1'b1;
    in_deep_sleep = 1'b0;
    startup_cycles = 16'h0004;
    sense = 4'ha;
    umask = 8'h00;
    lmask = 8'h00;
    en = 4'hf;
    gie = 1'b1;
    fclr = 4'h0;
    vtak = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wt(4);
    t_fall_vec;
    t_codes;
    t_change;
    t_sleep;
    t_startup;
    wrap_up;
  end
endmodule : epi_unit_tb_top
bind epi_unit epi_unit_chk u_chk (.*);
